// file: shared/watch_timer_pkg.sv
// Purpose: Constants shared by the watch/interval timer design and its bench
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Interrupt status and mask registers sit beside the mode register
`default_nettype none
package watch_timer_pkg;
    localparam logic [15:0] mode_index       = 16'hff6f;
    localparam logic [15:0] status_index     = 16'hff70;
    localparam logic [15:0] mask_index       = 16'hff71;
    localparam logic [17:0] mode_addr        = {mode_index, 2'b00};
    localparam logic [17:0] status_addr      = {status_index, 2'b00};
    localparam logic [17:0] mask_addr        = {mask_index, 2'b00};
    localparam logic [7:0]  mode_reset       = 8'h00;
    localparam logic [1:0]  mask_reset       = 2'h0;
    localparam int          mode_w           = 8;
    localparam int          presc_w          = 11;
    localparam int          wcnt_w           = 5;
    localparam int          div_w            = 7;
    localparam int          bit_clk_sel      = 7;
    localparam int          bit_ivl_hi       = 6;
    localparam int          bit_ivl_lo       = 4;
    localparam int          bit_wper_hi      = 3;
    localparam int          bit_wper_lo      = 2;
    localparam int          bit_run          = 1;
    localparam int          bit_enable       = 0;
    localparam int          ivl_base_exp     = 4;
    localparam int          slow_tap         = 8;
    localparam logic [1:0]  wper_14          = 2'h0;
    localparam logic [1:0]  wper_13          = 2'h1;
    localparam logic [1:0]  wper_5           = 2'h2;
    localparam logic [1:0]  wper_4           = 2'h3;
    localparam logic [4:0]  wcnt_top_32      = 5'h1f;
    localparam logic [4:0]  wcnt_top_16      = 5'h0f;
    localparam int          st_watch         = 0;
    localparam int          st_interval      = 1;
endpackage
`default_nettype wire

// file: logic/watch_interval_timer.sv
// Purpose: Watch timer and interval timer behind an APB slave
// Assumes: Subsystem clock arrives as a level input synchronous to pclk
// Notes:   Watch clock is a one-cycle tick; prescaler and counter advance on it
//          Each register's byte address is four times its index
// Behaviour
// - Watch and interval interrupts run concurrently
// - Five-bit counter and eleven-bit prescaler
// - Bit 7 picks divided clock or subclock
// - Bits 6:4 pick interval 2^(4+code)
// - Bits 3:2 pick watch period
// - Bit 1 starts counter, zero clears it
// - Bit 0 zero holds prescaler and counter cleared
// - Watch interrupt repeats every period
// - Interval interrupt repeats every interval
// - Mode register resets to zero
// - Mode register written as a whole byte through lane 0, readable
// - Watch counts only with bits 0,1 set
// - Clearing bit 1 leaves prescaler running
// - Interval depends only on bit 0
`default_nettype none
module watch_interval_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic        sub_clk_in,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             watch_interrupt_request,
    output logic             interval_interrupt_request,
    output logic             irq
);
    logic [7:0]  watch_mode_control_r;
    logic [1:0]  status_r;
    logic [1:0]  mask_r;
    logic [6:0]  div_r;
    logic [10:0] presc_r;
    logic [4:0]  wcnt_r;
    logic        sub_s1_r;
    logic        sub_s2_r;
    logic        sub_d_r;
    logic        fw_tick;
    logic        enable;
    logic        run;
    logic        count_clock_select;
    logic [2:0]  ivl_sel;
    logic [1:0]  wper_sel;
    logic [10:0] presc_nxt;
    logic        ivl_event;
    logic        wcnt_tick;
    logic [4:0]  wcnt_top;
    logic        watch_event;
    logic        setup;
    logic        wr;
    logic        rd;
    logic        hit_mode;
    logic        hit_status;
    logic        hit_mask;
    logic [7:0]  watch_mode_control_nxt;
    logic [1:0]  mask_nxt;
    logic [4:0]  wcnt_nxt;
    logic        div_wrap;
    logic        wcnt_slow_tick;
    logic [7:0]  ivl_fall;
    logic [1:0]  status_set;
    logic [1:0]  status_clr;
    logic        pending;
    logic [31:0] rd_data_nxt;
    logic        err_nxt;

    typedef enum logic [1:0] {
        sel_none   = 2'b00,
        sel_mode   = 2'b01,
        sel_status = 2'b10,
        sel_mask   = 2'b11
    } reg_sel_e;
    reg_sel_e    reg_sel;

    assign enable             = watch_mode_control_r[watch_timer_pkg::bit_enable];
    assign run                = watch_mode_control_r[watch_timer_pkg::bit_run];
    assign count_clock_select = watch_mode_control_r[watch_timer_pkg::bit_clk_sel];
    assign ivl_sel  = watch_mode_control_r[watch_timer_pkg::bit_ivl_hi:watch_timer_pkg::bit_ivl_lo];
    assign wper_sel = watch_mode_control_r[watch_timer_pkg::bit_wper_hi:watch_timer_pkg::bit_wper_lo];

    // APB decode; the slave answers in the access phase with no wait state
    assign setup      = psel && !penable;
    assign wr         = psel && penable && pwrite;
    assign rd         = psel && penable && !pwrite;
    assign hit_mode   = paddr == watch_timer_pkg::mode_addr;
    assign hit_status = paddr == watch_timer_pkg::status_addr;
    assign hit_mask   = paddr == watch_timer_pkg::mask_addr;

    // Subsystem clock synchroniser and rising-edge tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_s1_r <= 1'b0;
            sub_s2_r <= 1'b0;
        end else begin
            sub_s1_r <= sub_clk_in;
            sub_s2_r <= sub_s1_r;
        end
    end

    // Delayed copy for the edge detect; resets to the idle low level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_d_r <= 1'b0;
        end else begin
            sub_d_r <= sub_s2_r;
        end
    end

    // Divide-by-128 of pclk for the peripheral clock source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 7'h01;
        end
    end

    assign div_wrap = div_r == {watch_timer_pkg::div_w{1'b1}};
    assign fw_tick  = count_clock_select ? (sub_s2_r && !sub_d_r) : div_wrap;

    // Prescaler: cleared while disabled, ignores bit 1 entirely
    assign presc_nxt = presc_r + 11'h001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_r <= '0;
        end else if (!enable) begin
            presc_r <= '0;
        end else if (fw_tick) begin
            presc_r <= presc_nxt;
        end
    end

    // One falling edge of prescaler bit (3+code) per elapsed interval
    generate
        for (genvar k = 0; k < 8; k++) begin : g_ivl_tap
            assign ivl_fall[k] = presc_r[watch_timer_pkg::ivl_base_exp - 1 + k] &&
                                 !presc_nxt[watch_timer_pkg::ivl_base_exp - 1 + k];
        end
    endgenerate

    assign ivl_event = enable && fw_tick && ivl_fall[ivl_sel];

    // Prescaler bit 8 falls once every 2^9 watch ticks
    assign wcnt_slow_tick = fw_tick && presc_r[watch_timer_pkg::slow_tap] &&
                            !presc_nxt[watch_timer_pkg::slow_tap];

    // Counter clock: prescaler fw/2^9 tap for long periods, fw otherwise
    always_comb begin
        wcnt_tick = fw_tick;
        wcnt_top  = watch_timer_pkg::wcnt_top_32;
        unique case (wper_sel)
            watch_timer_pkg::wper_14: begin
                wcnt_tick = wcnt_slow_tick;
                wcnt_top  = watch_timer_pkg::wcnt_top_32;
            end
            watch_timer_pkg::wper_13: begin
                wcnt_tick = wcnt_slow_tick;
                wcnt_top  = watch_timer_pkg::wcnt_top_16;
            end
            watch_timer_pkg::wper_5: begin
                wcnt_tick = fw_tick;
                wcnt_top  = watch_timer_pkg::wcnt_top_32;
            end
            watch_timer_pkg::wper_4: begin
                wcnt_tick = fw_tick;
                wcnt_top  = watch_timer_pkg::wcnt_top_16;
            end
        endcase
    end

    assign watch_event = enable && run && wcnt_tick &&
                         ((wcnt_r & wcnt_top) == wcnt_top);

    // Five-bit counter, cleared whenever either control bit is low
    always_comb begin
        wcnt_nxt = wcnt_r;
        if (!enable || !run) begin
            wcnt_nxt = '0;
        end else if (wcnt_tick) begin
            wcnt_nxt = wcnt_r + 5'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wcnt_r <= '0;
        end else begin
            wcnt_r <= wcnt_nxt;
        end
    end

    // Single-cycle request pulses, both sources independent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watch_interrupt_request <= 1'b0;
        end else begin
            watch_interrupt_request <= watch_event;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interval_interrupt_request <= 1'b0;
        end else begin
            interval_interrupt_request <= ivl_event;
        end
    end

    // Mode register, byte lane 0 write strobe
    always_comb begin
        watch_mode_control_nxt = watch_mode_control_r;
        if (wr && hit_mode && pstrb[0]) begin
            watch_mode_control_nxt = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watch_mode_control_r <= watch_timer_pkg::mode_reset;
        end else begin
            watch_mode_control_r <= watch_mode_control_nxt;
        end
    end

    // Mask register, same layout as the status register
    always_comb begin
        mask_nxt = mask_r;
        if (wr && hit_mask && pstrb[0]) begin
            mask_nxt = pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= watch_timer_pkg::mask_reset;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // Sticky status; an event wins over the read-clear, and a read clears
    // only the bits that it returned, so an event after the setup is kept
    assign status_set[watch_timer_pkg::st_watch]    = watch_event;
    assign status_set[watch_timer_pkg::st_interval] = ivl_event;
    assign status_clr = (rd && hit_status) ? prdata[1:0] : 2'h0;

    generate
        for (genvar b = 0; b < 2; b++) begin : g_status
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    status_r[b] <= 1'b0;
                end else if (status_set[b]) begin
                    status_r[b] <= 1'b1;
                end else if (status_clr[b]) begin
                    status_r[b] <= 1'b0;
                end
            end
        end
    endgenerate

    // Level request while any unmasked sticky bit is set
    assign pending = |(status_r & mask_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= pending;
        end
    end

    // One register per aligned word; any other address is refused
    always_comb begin
        reg_sel = sel_none;
        if (hit_mode) begin
            reg_sel = sel_mode;
        end else if (hit_status) begin
            reg_sel = sel_status;
        end else if (hit_mask) begin
            reg_sel = sel_mask;
        end
    end

    // Read mux; the slave has no wait state, so data is captured at setup
    always_comb begin
        rd_data_nxt = '0;
        err_nxt     = 1'b0;
        unique case (reg_sel)
            sel_mode: begin
                rd_data_nxt = {24'h000000, watch_mode_control_r};
            end
            sel_status: begin
                rd_data_nxt = {30'h00000000, status_r};
            end
            sel_mask: begin
                rd_data_nxt = {30'h00000000, mask_r};
            end
            sel_none: begin
                err_nxt = 1'b1;
            end
        endcase
    end

    // Read data registered in the setup cycle, valid during access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup) begin
            prdata <= rd_data_nxt;
        end
    end

    // Error flag stands only in the access cycle, beside pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup && err_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end
endmodule
`default_nettype wire

// file: dv/watch_timer_monitor.sv
// Purpose: Port assertions for the watch/interval timer
// Assumes: Bound to the top module, one clock domain
// Notes:   Enable and run bits are tracked from APB writes
`default_nettype none
module watch_timer_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        sub_clk_in,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        watch_interrupt_request,
    input wire logic        interval_interrupt_request,
    input wire logic        irq
);
    logic [1:0] ctl_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctl_r <= 2'h0;
        else if (psel && penable && pready && pwrite && pstrb[0] &&
                 paddr == watch_timer_pkg::mode_addr)
            ctl_r <= pwdata[1:0];
    end
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence access_s;
        psel && penable;
    endsequence
    sequence setup_s;
        psel && !penable;
    endsequence
    ready_in_access_a: assert property (pready |-> access_s)
        else $error("ready outside access phase");
    ready_no_wait_a: assert property (setup_s |=> pready)
        else $error("ready missing in access phase");
    error_zero_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response malformed");
    read_upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    watch_pulse_a: assert property (watch_interrupt_request |=> !watch_interrupt_request)
        else $error("watch request longer than one cycle");
    interval_gap_a: assert property ($rose(interval_interrupt_request) |=>
        !interval_interrupt_request [*8])
        else $error("interval requests too close");
    disabled_quiet_a: assert property (!ctl_r[0] [*3] |->
        !interval_interrupt_request && !watch_interrupt_request)
        else $error("request while disabled");
    stopped_quiet_a: assert property (!ctl_r[1] [*3] |-> !watch_interrupt_request)
        else $error("watch request while counter stopped");
endmodule
bind watch_interval_timer watch_timer_monitor i_watch_timer_monitor (.*);
`default_nettype wire

// file: dv/watch_interval_timer_tb.sv
// Purpose: Self-checking bench for the watch/interval timer
// Assumes: Subclock toggles each cycle, one watch tick per two cycles with bit 7 set
// Notes:   Pulse gaps are measured in pclk cycles
`default_nettype none
module watch_interval_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct { logic [7:0] mode; int ivl; int wat; } row_s;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'h0;
    logic        sub_clk_in = 1'b0, pready, pslverr, er, sel_w = 1'b0;
    logic        watch_interrupt_request, interval_interrupt_request, irq;
    int          miscompares = 0, comparisons = 0, g;
    row_s        rows [10] = '{'{8'h8f, 32, 32}, '{8'h9b, 64, 64}, '{8'ha7, 128, 16384},
                               '{8'hb3, 256, 0}, '{8'hc1, 512, 0}, '{8'hd3, 1024, 0},
                               '{8'he3, 2048, 0}, '{8'hf3, 4096, 0}, '{8'h01, 2048, 0},
                               '{8'h8d, 32, 0}};
    wire logic   pulse_w = sel_w ? watch_interrupt_request : interval_interrupt_request;
    watch_interval_timer i_watch_interval_timer (.*);
    always #10 pclk = ~pclk;
    always @(posedge pclk) sub_clk_in <= ~sub_clk_in;
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic gap(input logic w);
        sel_w = w;
        do @(posedge pclk); while (pulse_w !== 1'b1);
        g = 0;
        do begin
            @(posedge pclk);
            g++;
        end while (pulse_w !== 1'b1);
    endtask
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #2_000_000;
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, watch_timer_pkg::mode_addr, 32'h0, 4'hf);
        check("mode reset", rd, 32'h0);
        apb(1'b0, watch_timer_pkg::mask_addr, 32'h0, 4'hf);
        check("mask reset", rd, 32'h0);
        apb(1'b1, watch_timer_pkg::mode_addr, 32'h5c, 4'hf);
        apb(1'b1, watch_timer_pkg::mode_addr, 32'hff, 4'h0);
        apb(1'b0, watch_timer_pkg::mode_addr, 32'h0, 4'hf);
        check("mode readback", rd, 32'h5c);
        apb(1'b0, 18'h00000, 32'h0, 4'hf);
        check("unmapped error", er, 1'b1);
        foreach (rows[i]) begin
            apb(1'b1, watch_timer_pkg::mode_addr, 32'h0, 4'hf);
            apb(1'b1, watch_timer_pkg::mode_addr, {24'h0, rows[i].mode}, 4'h1);
            gap(1'b0);
            check("interval gap", g, rows[i].ivl);
            if (rows[i].wat != 0) begin
                gap(1'b1);
                check("watch gap", g, rows[i].wat);
            end
        end
        apb(1'b1, watch_timer_pkg::mode_addr, 32'h0, 4'hf);
        check("irq masked", irq, 1'b0);
        apb(1'b1, watch_timer_pkg::mask_addr, 32'h3, 4'hf);
        repeat (2) @(posedge pclk);
        check("irq raised", irq, 1'b1);
        apb(1'b0, watch_timer_pkg::status_addr, 32'h0, 4'hf);
        check("status sticky", rd, 32'h3);
        repeat (2) @(posedge pclk);
        check("irq cleared", irq, 1'b0);
        apb(1'b1, watch_timer_pkg::mode_addr, 32'h8f, 4'h1);
        repeat (40) @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        check("reset outputs", {watch_interrupt_request, interval_interrupt_request, irq},
              32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, watch_timer_pkg::mode_addr, 32'h0, 4'hf);
        check("mode after reset", rd, 32'h0);
        apb(1'b0, watch_timer_pkg::status_addr, 32'h0, 4'hf);
        check("status after reset", rd, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
